// file: aic_pkg.sv
// constants and types for the interface config register and command issue
// assumes an 8-bit microcontroller data bus with a 16-bit address space
package aic_pkg;
	localparam logic [15:0] CFG_ONE_ADDR   = 16'hF0D1;
	localparam logic [7:0]  CFG_ONE_RESET  = 8'h00;
	// bit positions inside interface_config_one
	localparam int          DEV_SEL_BIT    = 0;
	localparam int          NO_DATA_BIT    = 1;
	localparam int          GO_BIT         = 2;
	localparam int          AUTO_CMD_BIT   = 3;
	localparam int          DIR_BIT        = 4;
	localparam int          DRV_RST_BIT    = 5;
	localparam int          SOFT_RST_BIT   = 6;
	localparam int          PROTO_BIT      = 7;
	// command parameter slots 0 through 15
	localparam logic [3:0]  SLOT_FIRST     = 4'h0;
	localparam logic [3:0]  SLOT_LAST      = 4'hF;
	localparam logic [3:0]  SLOT_DEVHEAD   = 4'h6;
	localparam int          DEVHEAD_DEV_BIT = 4;
	localparam logic [31:0] COUNT_RESET    = 32'h0000_0000;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;

	// stored configuration, ordered as in the register
	typedef struct packed {
		logic protocol_select;
		logic soft_reset;
		logic drive_reset_assert;
		logic transfer_direction;
		logic auto_command;
		logic transfer_go;
		logic no_data_command;
		logic drive_select;
	} aic_cfg_type;

	// one write toward the storage device task file
	typedef struct packed {
		logic       strobe;
		logic [3:0] slot;
		logic [7:0] data;
	} aic_devwr_type;
endpackage

// file: aic_cmd_seq.sv
// command issue sequencer: walks command parameter slots into the device
// assumes slot_data returns the addressed slot one cycle after slot_index
`timescale 1ns/1ps
module aic_cmd_seq (
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire logic                  ce,
	input  wire logic                  start,
	input  wire logic                  packet_mode,
	input  wire logic                  drive_select,
	input  wire logic [7:0]            slot_data,
	output logic      [3:0]            slot_index_ff,
	output aic_pkg::aic_devwr_type     devwr_ff,
	output logic                       busy_ff,
	output logic                       done_ff
);
	typedef enum logic [1:0] {AIC_IDLE, AIC_FETCH, AIC_LOAD} aic_seq_type;

	aic_seq_type            state_ff, nxt_state;
	logic                   pkt_ff, nxt_pkt;
	logic                   dsel_ff, nxt_dsel;
	logic [3:0]             nxt_index;
	aic_pkg::aic_devwr_type nxt_devwr;
	logic                   nxt_busy;
	logic                   nxt_done;

	// next state: fetch a slot, then load it, until slot 15 is loaded
	always_comb begin
		nxt_state = state_ff;
		nxt_pkt   = pkt_ff;
		nxt_dsel  = dsel_ff;
		nxt_index = slot_index_ff;
		nxt_devwr = '0;
		nxt_busy  = busy_ff;
		nxt_done  = 1'b0;
		case (state_ff)
			AIC_IDLE: begin
				if (start) begin // R5
					nxt_state = AIC_FETCH;
					nxt_index = aic_pkg::SLOT_FIRST;
					nxt_pkt   = packet_mode;
					nxt_dsel  = drive_select;
					nxt_busy  = 1'b1;
				end
			end
			AIC_FETCH: begin
				nxt_state = AIC_LOAD;
			end
			AIC_LOAD: begin
				nxt_devwr.strobe = 1'b1; // R5
				nxt_devwr.slot   = slot_index_ff;
				nxt_devwr.data   = slot_data;
				// packet command carries the chosen drive in the dev bit
				if (pkt_ff && slot_index_ff == aic_pkg::SLOT_DEVHEAD) begin
					nxt_devwr.data[aic_pkg::DEVHEAD_DEV_BIT] = dsel_ff; // R1
				end
				if (slot_index_ff == aic_pkg::SLOT_LAST) begin
					nxt_state = AIC_IDLE;
					nxt_busy  = 1'b0;
					nxt_done  = 1'b1;
				end else begin
					nxt_state = AIC_FETCH;
					nxt_index = slot_index_ff + 4'h1;
				end
			end
			default: begin
				nxt_state = AIC_IDLE;
			end
		endcase
	end

	// registers; reset includes the engine soft reset from the parent
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_ff      <= AIC_IDLE;
			pkt_ff        <= 1'b0;
			dsel_ff       <= 1'b0;
			slot_index_ff <= aic_pkg::SLOT_FIRST;
			devwr_ff      <= '0;
			busy_ff       <= 1'b0;
			done_ff       <= 1'b0;
		end else if (ce) begin
			state_ff      <= nxt_state;
			pkt_ff        <= nxt_pkt;
			dsel_ff       <= nxt_dsel;
			slot_index_ff <= nxt_index;
			devwr_ff      <= nxt_devwr;
			busy_ff       <= nxt_busy;
			done_ff       <= nxt_done;
		end
	end
endmodule // aic_cmd_seq

// file: ata_interface_control.sv
// interface_config_one register and transfer launch for the drive bus engine
// assumes a single-cycle microcontroller xdata bus, synchronous to mclk
//
// Functional notes
// (R1) ATAPI auto command go writes drive select into the device/head dev bit.
// (R2) Go bit is written 1, lasts one clock, then clears itself.
// (R3) Go starts command sending when auto command set, else data transfer.
// (R4) Started transfer size comes from the 32-bit transfer byte count.
// (R5) Auto command loads slots 0 to 15 into the device after go.
// (R6) Soft reset write gives a one-clock internal pulse; bit reads 0 after.
// (R7) Soft reset clears state machines, FIFO pointers and data buffer.
// (R8) Soft reset never touches reset signalling toward the storage device.
// (R9) Protocol bit: clear is ATA, set is ATAPI; packet path only ATAPI.
// (R10) Drive reset assert bit holds storage reset pin active while set.
`timescale 1ns/1ps
module ata_interface_control (
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire logic                  ce,
	input  wire logic [15:0]           xaddr,
	input  wire logic [7:0]            xwdata,
	input  wire logic                  xwr,
	input  wire logic                  xrd,
	input  wire logic [31:0]           transfer_byte_count,
	input  wire logic [7:0]            slot_data,
	output logic      [7:0]            xrdata_ff,
	output aic_pkg::aic_cfg_type       cfg_ff,
	output logic                       storage_reset_pin_n_ff,
	output logic                       engine_reset_ff,
	output logic                       data_start_ff,
	output logic                       packet_cmd_ff,
	output logic      [31:0]           xfer_count_ff,
	output logic      [3:0]            slot_index_ff,
	output aic_pkg::aic_devwr_type     devwr_ff,
	output logic                       cmd_busy_ff,
	output logic                       cmd_done_ff
);
	aic_pkg::aic_cfg_type nxt_cfg;
	logic [7:0]           nxt_rdata;
	logic                 nxt_rst_n;
	logic                 nxt_data_start;
	logic                 nxt_packet;
	logic [31:0]          nxt_count;
	logic                 seq_reset;
	logic                 seq_start;

	// address decode shared by read and write paths
	function automatic logic hit(input logic [15:0] a);
		return a == aic_pkg::CFG_ONE_ADDR;
	endfunction

	// register writes and self-clearing strobes
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_cfg.transfer_go = 1'b0; // R2
		nxt_cfg.soft_reset  = 1'b0; // R6
		if (xwr && hit(xaddr)) begin
			nxt_cfg = aic_pkg::aic_cfg_type'(xwdata);
		end
		// a pending go is dropped by soft reset so nothing restarts
		if (cfg_ff.soft_reset) begin
			nxt_cfg.transfer_go = 1'b0; // R7
		end
	end

	// read path: unmapped addresses return zero
	always_comb begin
		nxt_rdata = aic_pkg::BYTE_ZERO;
		if (xrd && hit(xaddr)) begin
			nxt_rdata = cfg_ff;
		end
	end

	// launch decisions, taken in the cycle the go bit is high
	always_comb begin
		nxt_data_start = 1'b0;
		nxt_packet     = 1'b0;
		nxt_count      = xfer_count_ff;
		if (cfg_ff.soft_reset) begin
			nxt_count = aic_pkg::COUNT_RESET; // R7
		end else if (cfg_ff.transfer_go) begin
			nxt_count      = transfer_byte_count; // R4
			nxt_data_start = !cfg_ff.auto_command; // R3
			nxt_packet     = cfg_ff.auto_command
				&& cfg_ff.protocol_select; // R9
		end
	end

	// drive reset follows only its own bit, never the soft reset
	always_comb begin
		nxt_rst_n = !cfg_ff.drive_reset_assert; // R10 R8
	end

	// soft reset acts on enabled edges only, so a frozen block stays put
	assign seq_reset = reset || (ce && cfg_ff.soft_reset); // R7
	assign seq_start = cfg_ff.transfer_go && cfg_ff.auto_command; // R3

	// register stage; every output except the u_seq ones (slot_index_ff, devwr_ff, cmd_busy_ff, cmd_done_ff) leaves from here
	always_ff @(posedge mclk) begin
		if (reset) begin
			cfg_ff                 <= aic_pkg::aic_cfg_type'(aic_pkg::CFG_ONE_RESET);
			xrdata_ff              <= aic_pkg::BYTE_ZERO;
			storage_reset_pin_n_ff <= 1'b1;
			engine_reset_ff        <= 1'b0;
			data_start_ff          <= 1'b0;
			packet_cmd_ff          <= 1'b0;
			xfer_count_ff          <= aic_pkg::COUNT_RESET;
		end else if (ce) begin
			cfg_ff                 <= nxt_cfg;
			xrdata_ff              <= nxt_rdata;
			storage_reset_pin_n_ff <= nxt_rst_n;
			engine_reset_ff        <= cfg_ff.soft_reset; // R6
			data_start_ff          <= nxt_data_start;
			packet_cmd_ff          <= nxt_packet;
			xfer_count_ff          <= nxt_count;
		end
	end

	// slot walker; cut short by the engine soft reset
	aic_cmd_seq u_seq (
		.mclk          (mclk),
		.reset         (seq_reset),
		.ce            (ce),
		.start         (seq_start),
		.packet_mode   (cfg_ff.protocol_select),
		.drive_select  (cfg_ff.drive_select),
		.slot_data     (slot_data),
		.slot_index_ff (slot_index_ff),
		.devwr_ff      (devwr_ff),
		.busy_ff       (cmd_busy_ff),
		.done_ff       (cmd_done_ff)
	);

	// checks
	go_one_cycle_a: assert property (@(posedge mclk) // R2
		disable iff (reset)
		ce && cfg_ff.transfer_go |=> !cfg_ff.transfer_go)
		else $error("go bit stayed high");

	soft_one_cycle_a: assert property (@(posedge mclk) // R6
		disable iff (reset)
		ce && cfg_ff.soft_reset |=> !cfg_ff.soft_reset
		&& engine_reset_ff)
		else $error("soft reset not a single pulse");

	data_start_a: assert property (@(posedge mclk) // R3
		disable iff (reset)
		ce && cfg_ff.transfer_go && !cfg_ff.auto_command
		&& !cfg_ff.soft_reset |=> data_start_ff)
		else $error("data transfer not started");

	cmd_start_a: assert property (@(posedge mclk) // R3
		disable iff (reset)
		ce && cfg_ff.transfer_go && cfg_ff.auto_command
		&& !cfg_ff.soft_reset && !cmd_busy_ff
		|=> cmd_busy_ff && !data_start_ff)
		else $error("command issue not started");

	count_latch_a: assert property (@(posedge mclk) // R4
		disable iff (reset)
		ce && cfg_ff.transfer_go && !cfg_ff.soft_reset
		|=> xfer_count_ff == $past(transfer_byte_count))
		else $error("byte count not taken");

	packet_mode_a: assert property (@(posedge mclk) // R9
		disable iff (reset)
		packet_cmd_ff |-> $past(cfg_ff.protocol_select))
		else $error("packet path used in ata mode");

	// an auto go in packet protocol must raise the packet command
	packet_start_a: assert property (@(posedge mclk) // R9
		disable iff (reset)
		ce && seq_start && cfg_ff.protocol_select && !cfg_ff.soft_reset
		|=> packet_cmd_ff)
		else $error("packet command not started");

	drive_reset_a: assert property (@(posedge mclk) // R10 R8
		disable iff (reset)
		ce && $past(ce) |-> storage_reset_pin_n_ff
		== !$past(cfg_ff.drive_reset_assert))
		else $error("storage reset pin wrong");

	soft_clear_a: assert property (@(posedge mclk) // R7
		disable iff (reset)
		ce && cfg_ff.soft_reset |=> !cmd_busy_ff
		&& xfer_count_ff == aic_pkg::COUNT_RESET)
		else $error("soft reset left engine state");

	// walk timing: slot k leaves 3 + 2k edges after the go cycle;
	// a soft reset in flight cancels these checks instead of failing them
	first_slot_a: assert property (@(posedge mclk) // R5
		disable iff (seq_reset)
		ce && seq_start && !cmd_busy_ff
		|-> ##3 devwr_ff.strobe && devwr_ff.slot == aic_pkg::SLOT_FIRST)
		else $error("first slot not loaded");

	slot_step_a: assert property (@(posedge mclk) // R5
		disable iff (seq_reset)
		ce && devwr_ff.strobe && devwr_ff.slot != aic_pkg::SLOT_LAST
		|-> ##2 devwr_ff.strobe
		&& devwr_ff.slot == $past(devwr_ff.slot, 2) + 4'h1)
		else $error("slots skipped or out of order");

	dev_bit_a: assert property (@(posedge mclk) // R1
		disable iff (seq_reset)
		ce && seq_start && cfg_ff.protocol_select && !cmd_busy_ff
		|-> ##15 devwr_ff.strobe
		&& devwr_ff.slot == aic_pkg::SLOT_DEVHEAD)
		else $error("device/head write missing");

	// the chosen drive lands in the dev bit of the device/head slot
	dev_value_a: assert property (@(posedge mclk) // R1
		disable iff (seq_reset)
		ce && seq_start && cfg_ff.protocol_select && !cmd_busy_ff
		|-> ##15 devwr_ff.data[aic_pkg::DEVHEAD_DEV_BIT]
		== $past(cfg_ff.drive_select, 15))
		else $error("dev bit not taken from drive select");

	// plain protocol passes the device/head slot through untouched
	ata_dev_pass_a: assert property (@(posedge mclk) // R9
		disable iff (seq_reset)
		ce && seq_start && !cfg_ff.protocol_select && !cmd_busy_ff
		|-> ##15 devwr_ff.data == $past(slot_data))
		else $error("device/head slot altered in ata mode");

	slot_walk_a: assert property (@(posedge mclk) // R5
		disable iff (reset)
		cmd_done_ff |-> devwr_ff.strobe
		&& devwr_ff.slot == aic_pkg::SLOT_LAST)
		else $error("walk ended before last slot");

	go_cmd_c: cover property (@(posedge mclk) disable iff (reset)
		seq_start ##[1:40] cmd_done_ff);
	go_data_c: cover property (@(posedge mclk) disable iff (reset)
		data_start_ff);
	soft_mid_c: cover property (@(posedge mclk) disable iff (reset)
		cmd_busy_ff && cfg_ff.soft_reset);
	drive_rst_c: cover property (@(posedge mclk) disable iff (reset)
		!storage_reset_pin_n_ff);
endmodule // ata_interface_control

// file: aic_slot_model.sv
// command parameter slot store facing the sequencer fetch port
// assumes the bench supplies a fill pattern and shares mclk
`timescale 1ns/1ps
module aic_slot_model (
	input  wire logic       mclk,
	input  wire logic [3:0] slot_index,
	input  wire logic [7:0] pattern,
	output logic      [7:0] slot_data
);
	// one cycle read latency; each slot differs so a misordered fetch shows
	always_ff @(posedge mclk) begin
		slot_data <= pattern + {slot_index, slot_index};
	end
endmodule // aic_slot_model

// file: test_ata_interface_control.sv
// self-checking bench for the interface config register and command issue
// assumes aic_pkg compiled first and the slot model beside the design
`timescale 1ns/1ps
module test_ata_interface_control;
	localparam logic [15:0] A = aic_pkg::CFG_ONE_ADDR;
	logic                   mclk, reset, ce, xwr, xrd, pin_n, eng, ds, pkt;
	logic                   busy, done, rd_hit;
	logic [15:0]            xaddr;
	logic [7:0]             xwdata, slot_data, xrdata_ff, pat;
	logic [31:0]            tbc, cnt;
	logic [3:0]             idx;
	aic_pkg::aic_cfg_type   cfg_ff;
	aic_pkg::aic_devwr_type devwr_ff;
	int                     fails = 0, checked = 0, cyc = 0;
	int                     n_pkt = 0, n_eng = 0, n_ds = 0, n_go = 0;
	logic [7:0]             rq[$];
	logic [12:0]            wq[$];
	logic [31:0]            cq[$];

	ata_interface_control ata_interface_control_i (
		.mclk(mclk), .reset(reset), .ce(ce), .xaddr(xaddr),
		.xwdata(xwdata), .xwr(xwr), .xrd(xrd), .transfer_byte_count(tbc),
		.slot_data(slot_data), .xrdata_ff(xrdata_ff), .cfg_ff(cfg_ff),
		.storage_reset_pin_n_ff(pin_n), .engine_reset_ff(eng),
		.data_start_ff(ds), .packet_cmd_ff(pkt), .xfer_count_ff(cnt),
		.slot_index_ff(idx), .devwr_ff(devwr_ff), .cmd_busy_ff(busy),
		.cmd_done_ff(done)
	);
	aic_slot_model aic_slot_model_i (
		.mclk(mclk), .slot_index(idx), .pattern(pat),
		.slot_data(slot_data)
	);

	// mismatch report and one compare task per kind of result
	task automatic note(string m);
		fails++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task automatic cmp_rd(logic [7:0] g, logic [7:0] e);
		checked++;
		if (g !== e) note("read data differs");
	endtask
	task automatic cmp_wr(logic [12:0] g, logic [12:0] e);
		checked++;
		if (g !== e) note("device write differs");
	endtask
	task automatic cmp_cnt(logic [31:0] g, logic [31:0] e);
		checked++;
		if (g !== e) note("count differs");
	endtask
	task automatic cmp_bit(logic g, logic e);
		checked++;
		if (g !== e) note("flag differs");
	endtask
	task automatic complete_run;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// single-cycle xdata strobes, launched just after an edge
	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge mclk);
		#1 xwr = 1'b1;
		xaddr = a;
		xwdata = d;
		@(posedge mclk);
		#1 xwr = 1'b0;
	endtask
	task automatic rd(logic [15:0] a, logic [7:0] e);
		rq.push_back(e);
		@(posedge mclk);
		#1 xrd = 1'b1;
		xaddr = a;
		@(posedge mclk);
		#1 xrd = 1'b0;
	endtask
	// note the sixteen slot writes, then launch and wait for completion
	task automatic cmd_run(logic [7:0] v);
		logic [7:0] b;
		for (int s = 0; s < 16; s++) begin
			b = pat + 8'(s * 17);
			if (s == aic_pkg::SLOT_DEVHEAD && v[aic_pkg::PROTO_BIT])
				b[aic_pkg::DEVHEAD_DEV_BIT] = v[aic_pkg::DEV_SEL_BIT];
			wq.push_back({1'b1, 4'(s), b});
		end
		wr(A, v);
		@(posedge mclk);
		#2 cmp_bit(busy, 1'b1);
		repeat (60) begin
			@(posedge mclk);
			#2;
			if (done === 1'b1) break;
		end
		cmp_bit(done, 1'b1);
		cmp_bit(busy, 1'b0);
	endtask

	// watcher: outputs looked at 2 ns after each edge, oldest note first
	always @(posedge mclk) begin
		rd_hit = xrd;
		#2;
		cyc++;
		if (rd_hit) cmp_rd(xrdata_ff, rq.pop_front());
		if (devwr_ff.strobe === 1'b1) cmp_wr(devwr_ff, wq.pop_front());
		if (ds === 1'b1) cmp_cnt(cnt, cq.pop_front());
		n_pkt += (pkt === 1'b1);
		n_eng += (eng === 1'b1);
		n_ds += (ds === 1'b1);
		n_go += (cfg_ff.transfer_go === 1'b1);
		if (cyc > 3000) begin
			note("timeout");
			complete_run();
		end
	end

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		reset = 1'b1;
		ce = 1'b1;
		xwr = 1'b0;
		xrd = 1'b0;
		xaddr = 16'h0000;
		xwdata = 8'h00;
		tbc = $urandom(32'h83A21279);
		tbc = $urandom();
		pat = 8'($urandom());
		repeat (12) @(posedge mclk);
		#1 reset = 1'b0;
		cmp_bit(pin_n, 1'b1);
		rd(A, aic_pkg::CFG_ONE_RESET);
		// data launch with direction set; go reads back cleared
		cq.push_back(tbc);
		wr(A, 8'h14);
		rd(A, 8'h10);
		// unmapped place ignores writes and reads zero
		wr(16'hF0D2, 8'hFF);
		rd(16'hF0D2, 8'h00);
		rd(A, 8'h10);
		// drive reset held across a soft reset pulse
		wr(A, 8'h22);
		#12 cmp_bit(pin_n, 1'b0);
		wr(A, 8'h62);
		rd(A, 8'h22);
		cmp_bit(pin_n, 1'b0);
		wr(A, 8'h00);
		#12 cmp_bit(pin_n, 1'b1);
		// a frozen clock enable ignores a data launch
		@(posedge mclk);
		#1 ce = 1'b0;
		wr(A, 8'h24);
		ce = 1'b1;
		rd(A, 8'h00);
		// soft reset cuts a running walk and clears the latched count
		wr(A, 8'h0C);
		wr(A, 8'h48);
		@(posedge mclk);
		#2 cmp_bit(busy, 1'b0);
		cmp_cnt(cnt, aic_pkg::COUNT_RESET);
		// auto issue: packet with each drive select, then plain protocol
		cmd_run(8'h8D);
		cmd_run(8'h8C);
		cmd_run(8'h0D);
		repeat (4) @(posedge mclk);
		cmp_cnt(n_go, 5);
		cmp_cnt(n_eng, 2);
		cmp_cnt(n_ds, 1);
		cmp_cnt(n_pkt, 2);
		cmp_cnt(wq.size(), 0);
		complete_run();
	end
endmodule // test_ata_interface_control
